/* File: rtl/xlat_test_pkg.sv */
// Constants shared by the translation buffer test access logic
`default_nettype none
package xlat_test_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [31:0] OFF_CMD        = 32'h0000_0000;
    localparam logic [31:0] OFF_DATA       = 32'h0000_0004;
    localparam logic [31:0] OFF_CTRL       = 32'h0000_0008;
    localparam logic [31:0] OFF_PDBR       = 32'h0000_000C;
    // ==========================================================
    // Command register fields
    localparam int          CMD_LIN_LSB    = 12;
    localparam int          CMD_VALID      = 11;
    localparam int          CMD_D          = 10;
    localparam int          CMD_DN         = 9;
    localparam int          CMD_U          = 8;
    localparam int          CMD_UN         = 7;
    localparam int          CMD_W          = 6;
    localparam int          CMD_WN         = 5;
    localparam int          CMD_OP         = 0;
    localparam logic [31:0] CMD_MASK       = 32'hFFFF_FFE1;
    // ==========================================================
    // Data register fields
    localparam int          DATA_PHYS_LSB  = 12;
    localparam int          DATA_HIT       = 4;
    localparam int          DATA_SEL_LSB   = 2;
    localparam logic [31:0] DATA_MASK      = 32'hFFFF_F01C;
    localparam logic [31:0] DATA_HIT_CLR   = 32'hFFFF_FFEF;
    // ==========================================================
    // Own control registers
    localparam int          CTRL_PAGING    = 0;
    localparam logic [31:0] CTRL_MASK      = 32'h0000_0001;
    localparam logic [31:0] PDBR_MASK      = 32'hFFFF_F000;
    // ==========================================================
    // Geometry, reset values and response codes
    localparam int          WAYS           = 4;
    localparam int          WAY_BITS       = 2;
    localparam int          PHYS_W         = 20;
    localparam logic [31:0] REG_RESET      = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;
endpackage
`default_nettype wire

/* File: rtl/xlat_store.sv */
// Entry storage of the associative translation buffer
`default_nettype none
module xlat_store
    import xlat_test_pkg::*;
#(
    parameter int SET_BITS = 3,
    parameter int TAGW     = 17
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     reset,
    // Maintenance
    input  wire logic                     clear_all,
    output logic                          valid_any,
    // Entry write port
    input  wire logic                     wr_en,
    input  wire logic [SET_BITS-1:0]      wr_set,
    input  wire logic [WAY_BITS-1:0]      wr_way,
    input  wire logic                     wr_valid,
    input  wire logic [TAGW-1:0]          wr_tag,
    input  wire logic [2:0]               wr_attr,
    input  wire logic [PHYS_W-1:0]        wr_phys,
    // Set read port
    input  wire logic [SET_BITS-1:0]      rd_set,
    output logic [WAYS-1:0]               rd_valid,
    output logic [WAYS*TAGW-1:0]          rd_tag,
    output logic [WAYS*3-1:0]             rd_attr,
    output logic [WAYS*PHYS_W-1:0]        rd_phys
);
    localparam int N = WAYS << SET_BITS;

    logic [N-1:0]        valid_r;
    logic [TAGW-1:0]     tag_r  [N];
    logic [2:0]          attr_r [N];
    logic [PHYS_W-1:0]   phys_r [N];
    wire  [SET_BITS+WAY_BITS-1:0] wr_idx = {wr_set, wr_way};

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            valid_r <= '0;
        end else if (clear_all) begin
            valid_r <= '0;
        end else if (wr_en) begin
            valid_r[wr_idx] <= wr_valid;
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            tag_r[wr_idx]  <= wr_tag;
            attr_r[wr_idx] <= wr_attr;
            phys_r[wr_idx] <= wr_phys;
        end
    end

    assign valid_any = |valid_r;

    for (genvar g = 0; g < WAYS; g++) begin : g_way
        wire [SET_BITS+WAY_BITS-1:0] idx = {rd_set, WAY_BITS'(g)};
        assign rd_valid[g]                 = valid_r[idx];
        assign rd_tag[g*TAGW +: TAGW]      = tag_r[idx];
        assign rd_attr[g*3 +: 3]           = attr_r[idx];
        assign rd_phys[g*PHYS_W +: PHYS_W] = phys_r[idx];
    end
endmodule
`default_nettype wire

/* File: rtl/xlat_match.sv */
// Tag and attribute comparison across the ways of one set
`default_nettype none
module xlat_match
    import xlat_test_pkg::*;
#(
    parameter int TAGW = 17
) (
    // Entries of the selected set
    input  wire logic [WAYS-1:0]          rd_valid,
    input  wire logic [WAYS*TAGW-1:0]     rd_tag,
    input  wire logic [WAYS*3-1:0]        rd_attr,
    input  wire logic [WAYS*PHYS_W-1:0]   rd_phys,
    // Search key: tag and true/complement pairs D, U, W
    input  wire logic [TAGW-1:0]          key_tag,
    input  wire logic [5:0]               key_pairs,
    // Result
    output logic                          hit_one,
    output logic [WAY_BITS-1:0]           hit_way,
    output logic [2:0]                    hit_attr,
    output logic [PHYS_W-1:0]             hit_phys
);
    function automatic logic pair_ok(input logic t, input logic c, input logic s);
        pair_ok = (t & s) | (c & ~s);
    endfunction

    logic [WAYS-1:0]   ok;
    logic [WAY_BITS:0] cnt;

    always_comb begin
        cnt      = '0;
        hit_way  = '0;
        hit_attr = '0;
        hit_phys = '0;
        for (int i = 0; i < WAYS; i++) begin
            ok[i] = rd_valid[i] && (rd_tag[i*TAGW +: TAGW] == key_tag)
                 && pair_ok(key_pairs[5], key_pairs[4], rd_attr[i*3+2])
                 && pair_ok(key_pairs[3], key_pairs[2], rd_attr[i*3+1])
                 && pair_ok(key_pairs[1], key_pairs[0], rd_attr[i*3]);
            if (ok[i]) begin
                cnt      = cnt + 1'b1;
                hit_way  = WAY_BITS'(i);
                hit_attr = rd_attr[i*3 +: 3];
                hit_phys = rd_phys[i*PHYS_W +: PHYS_W];
            end
        end
    end

    assign hit_one = (cnt == 1);
endmodule
`default_nettype wire

/* File: rtl/xlat_test_access.sv */
// Software test access to the translation buffer over AXI4-Lite
`default_nettype none
module xlat_test_access
    import xlat_test_pkg::*;
#(
    parameter int SET_BITS = 3
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          reset,
    // AXI4-Lite write address
    input  wire logic [31:0]   s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [31:0]   s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready
);
    localparam int TAGW = PHYS_W - SET_BITS;

    // ==========================================================
    // Helpers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction

    function automatic logic mapped(input logic [31:0] a);
        mapped = (a == OFF_CMD) || (a == OFF_DATA) || (a == OFF_CTRL) || (a == OFF_PDBR);
    endfunction

    function automatic logic attr_of(input logic t, input logic c);
        attr_of = t & ~c;
    endfunction

    // ==========================================================
    // Write channel capture
    logic                aw_have_r;
    logic [31:0]         aw_addr_r;
    logic                w_have_r;
    logic [31:0]         w_data_r;
    logic [3:0]          w_strb_r;
    logic                bvalid_r;
    logic [1:0]          bresp_r;

    assign s_axi_awready = !aw_have_r && !bvalid_r;
    assign s_axi_wready  = !w_have_r && !bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    wire do_write = aw_have_r && w_have_r && !bvalid_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= REG_RESET;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (do_write) begin
            aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            w_have_r <= 1'b0;
            w_data_r <= REG_RESET;
            w_strb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (do_write) begin
            w_have_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r  <= mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ==========================================================
    // Register state
    logic [31:0]         cmd_r;
    logic [31:0]         data_r;
    logic                paging_r;
    logic [31:0]         pdbr_r;
    logic [WAY_BITS-1:0] repl_r;

    wire wr_cmd  = do_write && (aw_addr_r == OFF_CMD);
    wire wr_data = do_write && (aw_addr_r == OFF_DATA);
    wire wr_ctrl = do_write && (aw_addr_r == OFF_CTRL);
    wire wr_pdbr = do_write && (aw_addr_r == OFF_PDBR);

    wire [31:0] cmd_wval  = merge(cmd_r, w_data_r, w_strb_r) & CMD_MASK;
    wire [31:0] data_wval = merge(data_r, w_data_r, w_strb_r) & DATA_MASK;
    wire [31:0] ctrl_wval = merge({31'h0, paging_r}, w_data_r, w_strb_r) & CTRL_MASK;

    wire test_go   = wr_cmd && !paging_r;
    wire lookup_op = test_go && cmd_wval[CMD_OP];
    wire write_op  = test_go && !cmd_wval[CMD_OP];

    // ==========================================================
    // Buffer storage and search
    wire [31:0]               key      = wr_cmd ? cmd_wval : cmd_r;
    wire [SET_BITS-1:0]       key_set  = key[CMD_LIN_LSB +: SET_BITS];
    wire [TAGW-1:0]           key_tag  = key[CMD_LIN_LSB+SET_BITS +: TAGW];
    wire [5:0]                key_pair = key[CMD_D:CMD_WN];
    wire                      place_r  = data_r[DATA_HIT];
    wire [WAY_BITS-1:0]       wr_way   = place_r ? data_r[DATA_SEL_LSB +: WAY_BITS]
                                                 : repl_r;
    wire [2:0]                wr_attr  = {attr_of(cmd_wval[CMD_D], cmd_wval[CMD_DN]),
                                          attr_of(cmd_wval[CMD_U], cmd_wval[CMD_UN]),
                                          attr_of(cmd_wval[CMD_W], cmd_wval[CMD_WN])};
    logic                     valid_any;
    logic [WAYS-1:0]          rd_valid;
    logic [WAYS*TAGW-1:0]     rd_tag;
    logic [WAYS*3-1:0]        rd_attr;
    logic [WAYS*PHYS_W-1:0]   rd_phys;
    logic                     hit_one;
    logic [WAY_BITS-1:0]      hit_way;
    logic [2:0]               hit_attr;
    logic [PHYS_W-1:0]        hit_phys;

    xlat_store #(.SET_BITS(SET_BITS), .TAGW(TAGW)) u_store (
        .clk       (clk),
        .reset     (reset),
        .clear_all (wr_pdbr),
        .valid_any (valid_any),
        .wr_en     (write_op),
        .wr_set    (key_set),
        .wr_way    (wr_way),
        .wr_valid  (cmd_wval[CMD_VALID]),
        .wr_tag    (key_tag),
        .wr_attr   (wr_attr),
        .wr_phys   (data_r[DATA_PHYS_LSB +: PHYS_W]),
        .rd_set    (key_set),
        .rd_valid  (rd_valid),
        .rd_tag    (rd_tag),
        .rd_attr   (rd_attr),
        .rd_phys   (rd_phys)
    );

    xlat_match #(.TAGW(TAGW)) u_match (
        .rd_valid  (rd_valid),
        .rd_tag    (rd_tag),
        .rd_attr   (rd_attr),
        .rd_phys   (rd_phys),
        .key_tag   (key_tag),
        .key_pairs (key_pair),
        .hit_one   (hit_one),
        .hit_way   (hit_way),
        .hit_attr  (hit_attr),
        .hit_phys  (hit_phys)
    );

    // ==========================================================
    // Next values of the test registers
    wire [31:0] cmd_hit  = {cmd_wval[31:CMD_LIN_LSB], 1'b1,
                            hit_attr[2], ~hit_attr[2], hit_attr[1], ~hit_attr[1],
                            hit_attr[0], ~hit_attr[0], 4'h0, cmd_wval[CMD_OP]};
    wire [31:0] data_hit = {hit_phys, 7'h00, 1'b1, hit_way, 2'b00};
    wire [31:0] cmd_nxt  = (lookup_op && hit_one) ? cmd_hit : cmd_wval;
    wire [31:0] data_nxt = !lookup_op ? data_wval
                         : hit_one    ? data_hit
                         :              (data_r & DATA_HIT_CLR);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmd_r <= REG_RESET;
        end else if (wr_cmd) begin
            cmd_r <= cmd_nxt;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            data_r <= REG_RESET;
        end else if (wr_data || lookup_op) begin
            data_r <= data_nxt;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            paging_r <= 1'b0;
            pdbr_r   <= REG_RESET;
        end else begin
            if (wr_ctrl) begin
                paging_r <= ctrl_wval[CTRL_PAGING];
            end
            if (wr_pdbr) begin
                pdbr_r <= merge(pdbr_r, w_data_r, w_strb_r) & PDBR_MASK;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            repl_r <= '0;
        end else if (write_op && !place_r) begin
            repl_r <= repl_r + 1'b1;
        end
    end

    // ==========================================================
    // Read channel
    logic                rvalid_r;
    logic [31:0]         rdata_r;
    logic [1:0]          rresp_r;

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    wire [31:0] rd_mux = (s_axi_araddr == OFF_CMD)  ? cmd_r
                       : (s_axi_araddr == OFF_DATA) ? data_r
                       : (s_axi_araddr == OFF_CTRL) ? {31'h0, paging_r}
                       : (s_axi_araddr == OFF_PDBR) ? pdbr_r
                       :                              REG_RESET;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rvalid_r <= 1'b0;
            rdata_r  <= REG_RESET;
            rresp_r  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    logic [WAY_BITS-1:0] last_way_r;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            last_way_r <= '0;
        end else if (write_op) begin
            last_way_r <= wr_way;
        end
    end
    wire [TAGW-1:0] chk_tag   = rd_tag[last_way_r*TAGW +: TAGW];
    wire            chk_valid = rd_valid[last_way_r];
    wire [2:0]      chk_attr  = rd_attr[last_way_r*3 +: 3];

    property p_paging_blocks;
        @(posedge clk) disable iff (reset)
        (wr_cmd && paging_r) |=> $stable(data_r) && ($past(repl_r) == repl_r);
    endproperty
    a_paging_blocks: assert property (p_paging_blocks) else $error("test op ran with paging on");

    property p_write_stores;
        @(posedge clk) disable iff (reset)
        write_op |=> (chk_tag == $past(key_tag)) && (chk_valid == $past(cmd_wval[CMD_VALID]));
    endproperty
    a_write_stores: assert property (p_write_stores) else $error("entry not written");

    property p_hit_loads;
        @(posedge clk) disable iff (reset)
        (lookup_op && hit_one) |=> data_r[DATA_PHYS_LSB +: PHYS_W] == $past(hit_phys)
                                   && cmd_r[CMD_VALID];
    endproperty
    a_hit_loads: assert property (p_hit_loads) else $error("hit did not load fields");

    property p_miss_keeps;
        @(posedge clk) disable iff (reset)
        (lookup_op && !hit_one) |=> !data_r[DATA_HIT]
            && (data_r[31:DATA_PHYS_LSB] == $past(data_r[31:DATA_PHYS_LSB]));
    endproperty
    a_miss_keeps: assert property (p_miss_keeps) else $error("miss changed fields");

    property p_hit_flag;
        @(posedge clk) disable iff (reset)
        (lookup_op && hit_one) |=> data_r[DATA_HIT]
            && (data_r[DATA_SEL_LSB +: WAY_BITS] == $past(hit_way));
    endproperty
    a_hit_flag: assert property (p_hit_flag) else $error("hit flag not set");

    property p_repl_step;
        @(posedge clk) disable iff (reset)
        write_op |=> repl_r == ($past(place_r) ? $past(repl_r) : $past(repl_r) + 2'd1);
    endproperty
    a_repl_step: assert property (p_repl_step) else $error("replacement pointer wrong");

    property p_clear_all;
        @(posedge clk) disable iff (reset)
        wr_pdbr |=> !valid_any;
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("valid bits survived clear");

    property p_pair_miss;
        @(posedge clk) disable iff (reset)
        (lookup_op && (key_pair[5:4] == 2'b00)) |-> !hit_one;
    endproperty
    a_pair_miss: assert property (p_pair_miss) else $error("pair 00 matched");

    property p_attr_store;
        @(posedge clk) disable iff (reset)
        (write_op && (cmd_wval[CMD_D] != cmd_wval[CMD_DN])) |=>
            chk_attr[2] == $past(cmd_wval[CMD_D]);
    endproperty
    a_attr_store: assert property (p_attr_store) else $error("attribute stored wrong");

    property p_bresp_time;
        @(posedge clk) disable iff (reset)
        do_write |=> s_axi_bvalid;
    endproperty
    a_bresp_time: assert property (p_bresp_time) else $error("write response late");
endmodule
`default_nettype wire

/* File: verif/xlat_test_access_tb.sv */
// Self-checking bench for the translation buffer test access block
`default_nettype none
module xlat_test_access_tb
    import xlat_test_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, strb_m;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          err_total = 0, checked = 0, cyc = 0;
    // ==========================================================
    // Reference model state
    logic [31:0] cmd_m, data_m, ctrl_m, pdbr_m;
    logic [1:0]  ptr_m;
    logic        v_m [8][4];
    logic [16:0] t_m [8][4];
    logic [2:0]  a_m [8][4];
    logic [19:0] p_m [8][4];
    logic [19:0] lin_q [$];

    xlat_test_access #(.SET_BITS(3)) xlat_test_access_inst (
        .clk(clk), .reset(reset),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ==========================================================
    // Comparison, model and bus tasks
    task automatic tally_and_finish();
        if (err_total == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp2(input logic [1:0] got, input logic [1:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic pass(input logic [2:0] x, input logic [5:0] p);
        pass = 1'b1;
        for (int k = 0; k < 3; k++)
            if (!(p[2*k+1] && x[k] || p[2*k] && !x[k])) pass = 1'b0;
    endfunction
    function automatic logic [1:0] m_wr(input logic [31:0] a, input logic [31:0] d);
        logic [2:0] s;
        logic [1:0] w;
        int         n;
        logic [31:0] o;
        m_wr = RESP_OKAY;
        o = m_rd(a);
        for (int b = 0; b < 4; b++)
            if (!strb_m[b]) d[b*8 +: 8] = o[b*8 +: 8];
        s = d[14:12];
        n = 0;
        w = ptr_m;
        case (a)
            OFF_CMD: begin
                cmd_m = d & CMD_MASK;
                if (!ctrl_m[0] && !d[0]) begin
                    if (data_m[4]) w = data_m[3:2];
                    ptr_m = ptr_m + {1'b0, !data_m[4]};
                    v_m[s][w] = d[11];
                    t_m[s][w] = d[31:15];
                    a_m[s][w] = {d[10] & !d[9], d[8] & !d[7], d[6] & !d[5]};
                    p_m[s][w] = data_m[31:12];
                end else if (!ctrl_m[0]) begin
                    for (int i = 0; i < 4; i++)
                        if (v_m[s][i] && t_m[s][i] == d[31:15] && pass(a_m[s][i], d[10:5])) begin
                            n++;
                            w = 2'(i);
                        end
                    if (n == 1) begin
                        cmd_m[11] = 1'b1;
                        for (int k = 0; k < 3; k++) begin
                            cmd_m[6+2*k] = a_m[s][w][k];
                            cmd_m[5+2*k] = !a_m[s][w][k];
                        end
                        data_m = {p_m[s][w], 7'h00, 1'b1, w, 2'b00};
                    end else data_m[4] = 1'b0;
                end
            end
            OFF_DATA: data_m = d & DATA_MASK;
            OFF_CTRL: ctrl_m = d & CTRL_MASK;
            OFF_PDBR: begin
                pdbr_m = d & PDBR_MASK;
                foreach (v_m[i, j]) v_m[i][j] = 1'b0;
            end
            default: m_wr = RESP_SLVERR;
        endcase
    endfunction
    function automatic logic [31:0] m_rd(input logic [31:0] a);
        case (a)
            OFF_CMD:  m_rd = cmd_m;
            OFF_DATA: m_rd = data_m;
            OFF_CTRL: m_rd = ctrl_m;
            OFF_PDBR: m_rd = pdbr_m;
            default:  m_rd = 32'h0000_0000;
        endcase
    endfunction
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [1:0] e;
        e = m_wr(a, d);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= strb_m;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        cmp2(s_axi_bresp, e);
        @(posedge clk);
    endtask
    task automatic rd(input logic [31:0] a);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        cmp32(s_axi_rdata, m_rd(a));
        cmp2(s_axi_rresp, a <= OFF_PDBR ? RESP_OKAY : RESP_SLVERR);
        @(posedge clk);
    endtask
    // ==========================================================
    // Timeout and main sequence
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        logic [19:0] lin;
        logic [31:0] r;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hF;
        strb_m = 4'hF;
        {cmd_m, data_m, ctrl_m, pdbr_m} = '0;
        ptr_m = 2'b00;
        foreach (v_m[i, j]) v_m[i][j] = 1'b0;
        reset = 1'b1;
        void'($urandom(19));
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 5; i++) rd(32'(4 * i));
        wr(32'h0000_0010, 32'hFFFF_FFFF);
        repeat (24) begin
            lin = {15'h0000, 2'($urandom_range(3)), 3'($urandom_range(7))};
            lin_q.push_back(lin);
            r = $urandom;
            wr(OFF_DATA, $urandom);
            wr(OFF_CMD, {lin, r[31] | r[30], r[2], !r[2], r[1], !r[1], r[0], !r[0], r[8:5], 1'b0});
        end
        repeat (48) begin
            r = $urandom;
            lin = r[3] ? lin_q[$urandom_range(23)] : r[31:12];
            wr(OFF_CMD, {lin, r[11], r[10:5] | {6{r[20]}}, r[4:1], 1'b1});
            rd(OFF_DATA);
            rd(OFF_CMD);
        end
        // Random byte strobes on eight writes to randomly chosen registers
        repeat (8) begin
            strb_m = 4'($urandom);
            r = 32'(4 * $urandom_range(3));
            wr(r, $urandom);
            rd(r);
        end
        strb_m = 4'hF;
        wr(OFF_CTRL, 32'h0000_0001);
        wr(OFF_DATA, 32'h1234_5010);
        wr(OFF_CMD, {lin_q[0], 12'hFE1});
        rd(OFF_DATA);
        wr(OFF_CMD, {lin_q[1], 12'hAA0});
        wr(OFF_CTRL, 32'h0000_0000);
        wr(OFF_CMD, {lin_q[1], 12'hFE1});
        rd(OFF_DATA);
        wr(OFF_PDBR, $urandom);
        wr(OFF_CMD, {lin_q[0], 12'hFE1});
        rd(OFF_DATA);
        rd(OFF_PDBR);
        tally_and_finish();
    end
endmodule
`default_nettype wire
